// ===== hw/seq_consts.svh
// offsets, field positions, reset values and cycle figures of the sequencer
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH
`define OFS_INSTR 8'h00
`define OFS_STATUS 8'h04
`define OFS_CUR_SW 8'h08
`define OFS_SAVED_SW 8'h0c
`define OFS_REGS 8'h40
`define MASK_REGS 8'hc0
`define OFS_USER 8'h80
`define MASK_USER 8'he0
`define STAT_BUSY 0
`define STAT_FAULT 1
`define STAT_LOCKED 2
`define BIT_PRE 24
`define BIT_UP 23
`define BIT_SBIT 22
`define BIT_WB 21
`define BIT_LOAD 20
`define BASE_LO 16
`define DEST_LO 12
`define SRC_LO 0
`define CLASS_BLOCK 3'h4
`define CLASS_SWAP 5'h02
`define SWAP_MARK 4'h9
`define SW_RESET 32'h0000_0013
`define PC_IDX 4'hf
`define NO_REG 5'h10
`define LDM_EXTRA 6'h02
`define LDM_PC_EXTRA 6'h04
`define STM_EXTRA 6'h01
`define SWP_CYCLES 6'h04
`endif

// ===== hw/seq_pkg.sv
// types shared by the block transfer and swap sequencer
package seq_pkg;
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_SETUP = 9'h002,
    ST_XFER = 9'h004,
    ST_WRAP = 9'h008,
    ST_FILL_N = 9'h010,
    ST_FILL_S = 9'h020,
    ST_SWP_RD = 9'h040,
    ST_SWP_WR = 9'h080,
    ST_SWP_I = 9'h100
  } state_t;
  typedef enum logic [1:0] {
    CYC_N = 2'h0,
    CYC_S = 2'h1,
    CYC_I = 2'h2
  } cyc_t;
  typedef struct packed {
    logic req;
    logic we;
    logic lock;
    logic byteXfer;
    cyc_t cyc;
    logic [31:0] addr;
    logic [31:0] wdata;
  } memOut_t;
  typedef struct packed {
    logic [31:0] rdata;
    logic fault;
  } memIn_t;
  typedef struct packed {
    logic isSwap;
    logic isBlock;
    logic load;
    logic pre;
    logic up;
    logic sBit;
    logic wBit;
    logic [3:0] base;
    logic [3:0] dest;
    logic [3:0] src;
    logic [15:0] list;
  } instr_t;
endpackage

// ===== hw/block_transfer_swap_sequencer.sv
// block transfer and atomic exchange sequencer with wishbone access
//
// Summary of operation
// - loading pc with user-bank bit copies saved status into current status
// - store with pc and user-bank bit takes values from user bank
// - user-bank bit without pc transfers user bank for load and store
// - base written back end of cycle two; first store sees old base
// - a loaded base overrides the written-back base
// - memory fault may hit any word; handled recoverably
// - store fault runs to completion then traps; only write-back changes
// - load fault stops register writes from faulting word; pc kept
// - after load fault base restored, to written-back value if asked
// - load fault trap taken only after whole sequence completes
// - load takes nS+1N+1I, with pc (n+1)S+2N+1I cycles
// - store takes (n-1)S+2N cycles
// - decode load, before/after and up/down bits into four modes
// - exchange read and write inseparable; no interrupt in between
// - exchange reads base address, writes source, old value to dest
// - lock output high across exchange read and write
// - exchange byte bit selects byte transfer, else word
// - fault on exchange read or write takes the data fault trap
// - exchange takes 1S+2N+1I cycles
// - register list is 16 bits, bit k selects register k
// - lowest register first at lowest address, pc last
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`include "seq_consts.svh"
module block_transfer_swap_sequencer #(
  parameter int LIST_W = 16
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic ack_o,
  output logic [31:0] dat_o,
  // memory system
  output seq_pkg::memOut_t memOut,
  input wire seq_pkg::memIn_t memIn,
  // core status
  output logic busy,
  output logic irqInhibit,
  output logic dataFaultTrap,
  output logic instrDone
);
  import seq_pkg::*;

  if (LIST_W != 16)
  begin : g_check
    $error("register list must be 16 bits wide");
  end

  state_t state_q, state_d;
  instr_t ins_q, dec;
  memOut_t memD;
  logic [31:0] regs_q [16];
  logic [31:0] userHi_q [7];
  logic [31:0] curSw_q, savedSw_q, origBase_q, newBase_q, addr_q, swapData_q;
  logic [31:0] rdD, span, startBase;
  logic [4:0] idx_q, nWords_q, nxt, first, cnt;
  logic [5:0] cycCnt_q;
  logic useUser_q, faulted_q, wbDone_q, busWr, startReq, faultNow, loadOk;

  function automatic logic [4:0] nextSet(logic [15:0] l, logic [4:0] from);
    logic [4:0] r;
    r = `NO_REG;
    for (int k = 15; k >= 0; k--)
    begin
      if (l[k] && 5'(k) >= from)
        r = 5'(k);
    end
    return r;
  endfunction

  function automatic logic [4:0] popCount(logic [15:0] l);
    logic [4:0] r;
    r = 5'h0;
    for (int k = 0; k < 16; k++)
      r = r + {4'h0, l[k]};
    return r;
  endfunction

  function automatic logic isBanked(logic [3:0] i);
    return i[3] && i != `PC_IDX;
  endfunction

  function automatic logic [31:0] mergeSel(logic [31:0] o, logic [31:0] n,
                                           logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
        r[b*8 +: 8] = n[b*8 +: 8];
    end
    return r;
  endfunction

  // value sent out for a stored register
  function automatic logic [31:0] storeVal(logic [3:0] r);
    logic [31:0] v;
    v = (useUser_q && isBanked(r)) ? userHi_q[r[2:0]]
                                   : regs_q[r];
    if (r == ins_q.base && ins_q.wBit && state_q == ST_XFER && !wbDone_q)
      v = newBase_q;
    return v;
  endfunction

  // instruction decode
  always_comb
  begin
    dec = '0;
    dec.isBlock = dat_i[27:25] == `CLASS_BLOCK;
    dec.isSwap = dat_i[27:23] == `CLASS_SWAP && dat_i[21:20] == 2'h0
                 && dat_i[7:4] == `SWAP_MARK;
    dec.load = dat_i[`BIT_LOAD] && dec.isBlock;
    dec.pre = dat_i[`BIT_PRE];
    dec.up = dat_i[`BIT_UP];
    dec.sBit = dat_i[`BIT_SBIT];
    dec.wBit = dat_i[`BIT_WB] && dec.isBlock;
    dec.base = dat_i[`BASE_LO +: 4];
    dec.dest = dat_i[`DEST_LO +: 4];
    dec.src = dat_i[`SRC_LO +: 4];
    dec.list = dec.isBlock ? dat_i[15:0] : 16'h0;
  end

  // writes land at the edge where the master sees ack
  assign busWr = cyc_i && stb_i && we_i && ack_o;
  assign startReq = busWr && adr_i == `OFS_INSTR && state_q == ST_IDLE
                    && (dec.isBlock || dec.isSwap);
  assign cnt = popCount(dec.list);
  assign span = {25'h0, cnt, 2'h0};
  assign startBase = regs_q[dec.base];
  assign nxt = nextSet(ins_q.list, idx_q + 5'h1);
  assign first = nextSet(ins_q.list, 5'h0);
  assign faultNow = memOut.req && memIn.fault;
  assign loadOk = state_q == ST_XFER && ins_q.load && !faulted_q
                  && !memIn.fault;

  // sequencing of bus cycles
  always_comb
  begin
    state_d = state_q;
    memD = '0;
    memD.cyc = CYC_I;
    memD.byteXfer = ins_q.isSwap && ins_q.sBit;
    case (state_q)
      ST_IDLE:
        if (startReq)
        begin
          state_d = ST_SETUP;
          memD.cyc = dec.isSwap ? CYC_S : CYC_N;
        end
      ST_SETUP:
        if (ins_q.isSwap)
        begin
          state_d = ST_SWP_RD;
          memD.req = 1'b1;
          memD.lock = 1'b1;
          memD.cyc = CYC_N;
          memD.addr = origBase_q;
        end
        else if (first[4])
          state_d = ins_q.load ? ST_WRAP : ST_IDLE;
        else
        begin
          state_d = ST_XFER;
          memD.req = 1'b1;
          memD.we = !ins_q.load;
          memD.cyc = ins_q.load ? CYC_S : CYC_N;
          memD.addr = addr_q;
          memD.wdata = storeVal(first[3:0]);
        end
      ST_XFER:
        if (nxt[4])
          state_d = ins_q.load ? ST_WRAP : ST_IDLE;
        else
        begin
          memD.req = 1'b1;
          memD.we = !ins_q.load;
          memD.cyc = CYC_S;
          memD.addr = memOut.addr + 32'h4;
          memD.wdata = storeVal(nxt[3:0]);
        end
      ST_WRAP:
        if (ins_q.list[`PC_IDX] && !faulted_q)
        begin
          state_d = ST_FILL_N;
          memD.cyc = CYC_N;
        end
        else
          state_d = ST_IDLE;
      ST_FILL_N:
      begin
        state_d = ST_FILL_S;
        memD.cyc = CYC_S;
      end
      ST_FILL_S:
        state_d = ST_IDLE;
      ST_SWP_RD:
      begin
        state_d = ST_SWP_WR;
        memD.req = 1'b1;
        memD.we = 1'b1;
        memD.lock = 1'b1;
        memD.cyc = CYC_N;
        memD.addr = origBase_q;
        memD.wdata = ins_q.sBit ? {4{regs_q[ins_q.src][7:0]}}
                                : regs_q[ins_q.src];
      end
      ST_SWP_WR:
        state_d = ST_SWP_I;
      ST_SWP_I:
        state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      memOut <= '0;
      irqInhibit <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      memOut <= memD;
      irqInhibit <= state_d inside {ST_SWP_RD, ST_SWP_WR, ST_SWP_I};
      busy <= state_d != ST_IDLE;
    end
  end

  // captured instruction and addressing
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ins_q <= '0;
      origBase_q <= 32'h0;
      newBase_q <= 32'h0;
      addr_q <= 32'h0;
      nWords_q <= 5'h0;
      useUser_q <= 1'b0;
      idx_q <= 5'h0;
    end
    else if (startReq)
    begin
      ins_q <= dec;
      origBase_q <= startBase;
      nWords_q <= cnt;
      newBase_q <= dec.up ? startBase + span : startBase - span;
      if (dec.up)
        addr_q <= dec.pre ? startBase + 32'h4 : startBase;
      else
        addr_q <= dec.pre ? startBase - span : startBase - span + 32'h4;
      useUser_q <= dec.sBit && dec.isBlock
                   && !(dec.load && dec.list[`PC_IDX]);
    end
    else if (state_q == ST_SETUP)
      idx_q <= first;
    else if (state_q == ST_XFER)
      idx_q <= nxt;
  end

  // fault tracking, write-back progress and completion
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      faulted_q <= 1'b0;
      wbDone_q <= 1'b0;
      swapData_q <= 32'h0;
      dataFaultTrap <= 1'b0;
      instrDone <= 1'b0;
      cycCnt_q <= 6'h0;
    end
    else
    begin
      if (startReq)
      begin
        faulted_q <= 1'b0;
        wbDone_q <= 1'b0;
        cycCnt_q <= 6'h1;
      end
      else
      begin
        if (faultNow)
          faulted_q <= 1'b1;
        if (state_q == ST_XFER)
          wbDone_q <= 1'b1;
        if (state_q != ST_IDLE && state_d != ST_IDLE)
          cycCnt_q <= cycCnt_q + 6'h1;
      end
      if (state_q == ST_SWP_RD)
        swapData_q <= ins_q.sBit
          ? {24'h0, memIn.rdata[{memOut.addr[1:0], 3'h0} +: 8]}
          : memIn.rdata;
      instrDone <= state_q != ST_IDLE && state_d == ST_IDLE;
      dataFaultTrap <= state_q != ST_IDLE && state_d == ST_IDLE
                       && (faulted_q || faultNow);
    end
  end

  // register banks and status words
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int k = 0; k < 16; k++)
        regs_q[k] <= 32'h0;
      for (int k = 0; k < 7; k++)
        userHi_q[k] <= 32'h0;
      curSw_q <= `SW_RESET;
      savedSw_q <= `SW_RESET;
    end
    else
    begin
      if (busWr && state_q == ST_IDLE)
      begin
        if (adr_i == `OFS_CUR_SW)
          curSw_q <= mergeSel(curSw_q, dat_i, sel_i);
        if (adr_i == `OFS_SAVED_SW)
          savedSw_q <= mergeSel(savedSw_q, dat_i, sel_i);
        if ((adr_i & `MASK_REGS) == `OFS_REGS)
          regs_q[adr_i[5:2]] <= mergeSel(regs_q[adr_i[5:2]], dat_i, sel_i);
        if ((adr_i & `MASK_USER) == `OFS_USER && adr_i[4:2] != 3'h7)
          userHi_q[adr_i[4:2]] <= mergeSel(userHi_q[adr_i[4:2]], dat_i,
                                           sel_i);
      end
      if (state_q == ST_XFER && !wbDone_q && ins_q.wBit)
        regs_q[ins_q.base] <= newBase_q;
      if (loadOk)
      begin
        if (useUser_q && isBanked(idx_q[3:0]))
          userHi_q[idx_q[2:0]] <= memIn.rdata;
        else
          regs_q[idx_q[3:0]] <= memIn.rdata;
        if (idx_q[3:0] == `PC_IDX && ins_q.sBit)
          curSw_q <= savedSw_q;
      end
      if (state_q == ST_WRAP && faulted_q)
        regs_q[ins_q.base] <= ins_q.wBit ? newBase_q : origBase_q;
      if (state_q == ST_SWP_WR && !faulted_q)
        regs_q[ins_q.dest] <= swapData_q;
    end
  end

  // register bus answer
  always_comb
  begin
    rdD = 32'h0;
    if (adr_i == `OFS_STATUS)
    begin
      rdD[`STAT_BUSY] = busy;
      rdD[`STAT_FAULT] = faulted_q;
      rdD[`STAT_LOCKED] = irqInhibit;
    end
    else if (adr_i == `OFS_CUR_SW)
      rdD = curSw_q;
    else if (adr_i == `OFS_SAVED_SW)
      rdD = savedSw_q;
    else if ((adr_i & `MASK_REGS) == `OFS_REGS)
      rdD = regs_q[adr_i[5:2]];
    else if ((adr_i & `MASK_USER) == `OFS_USER && adr_i[4:2] != 3'h7)
      rdD = userHi_q[adr_i[4:2]];
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end
    else
    begin
      ack_o <= cyc_i && stb_i && !ack_o;
      dat_o <= (cyc_i && stb_i && !we_i && !ack_o) ? rdD : 32'h0;
    end
  end

  sequence s_swap_read;
    memOut.req && memOut.lock && !memOut.we;
  endsequence
  sequence s_swap_write;
    memOut.req && memOut.lock && memOut.we;
  endsequence

  property p_swap_pair;
    @(posedge clk_sys) disable iff (rst)
    s_swap_read |=> s_swap_write ##1 !memOut.lock;
  endproperty
  a_swap_pair: assert property (p_swap_pair)
    else $error("exchange read not followed by locked write");

  property p_lock_span;
    @(posedge clk_sys) disable iff (rst)
    state_q inside {ST_SWP_RD, ST_SWP_WR} |-> memOut.lock && memOut.req;
  endproperty
  a_lock_span: assert property (p_lock_span)
    else $error("lock low during exchange access");

  property p_irq_hold;
    @(posedge clk_sys) disable iff (rst)
    memOut.lock |-> irqInhibit ##1 irqInhibit;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupts allowed inside exchange");

  property p_wb_timing;
    @(posedge clk_sys) disable iff (rst)
    state_q == ST_XFER && !wbDone_q && ins_q.wBit
      && !(ins_q.load && idx_q[3:0] == ins_q.base)
      |=> regs_q[ins_q.base] == newBase_q;
  endproperty
  a_wb_timing: assert property (p_wb_timing)
    else $error("base not written back after second cycle");

  property p_status_copy;
    @(posedge clk_sys) disable iff (rst)
    loadOk && idx_q[3:0] == `PC_IDX && ins_q.sBit
      |=> curSw_q == $past(savedSw_q);
  endproperty
  a_status_copy: assert property (p_status_copy)
    else $error("status word not copied with pc load");

  property p_pc_kept;
    @(posedge clk_sys) disable iff (rst)
    state_q == ST_XFER && ins_q.load && (faulted_q || memIn.fault)
      |=> $stable(regs_q[15]);
  endproperty
  a_pc_kept: assert property (p_pc_kept)
    else $error("pc changed after load fault");

  property p_restore;
    @(posedge clk_sys) disable iff (rst)
    state_q == ST_WRAP && faulted_q && ins_q.wBit
      |=> regs_q[ins_q.base] == newBase_q;
  endproperty
  a_restore: assert property (p_restore)
    else $error("base not restored after load fault");

  property p_trap_late;
    @(posedge clk_sys) disable iff (rst)
    faulted_q && state_q != ST_IDLE
      |-> !dataFaultTrap ##[1:20] (dataFaultTrap && instrDone);
  endproperty
  a_trap_late: assert property (p_trap_late)
    else $error("fault trap not taken at completion");

  property p_ascend;
    @(posedge clk_sys) disable iff (rst)
    state_q == ST_XFER && state_d == ST_XFER
      |=> memOut.addr == $past(memOut.addr) + 32'h4;
  endproperty
  a_ascend: assert property (p_ascend)
    else $error("transfer address not ascending by a word");

  property p_ldm_cycles;
    @(posedge clk_sys) disable iff (rst)
    instrDone && ins_q.load && !dataFaultTrap
      |-> cycCnt_q == {1'b0, nWords_q} + (ins_q.list[`PC_IDX]
                      ? `LDM_PC_EXTRA : `LDM_EXTRA);
  endproperty
  a_ldm_cycles: assert property (p_ldm_cycles)
    else $error("load multiple cycle count wrong");

  property p_stm_cycles;
    @(posedge clk_sys) disable iff (rst)
    instrDone && ins_q.isBlock && !ins_q.load && nWords_q != 5'h0
      |-> cycCnt_q == {1'b0, nWords_q} + `STM_EXTRA;
  endproperty
  a_stm_cycles: assert property (p_stm_cycles)
    else $error("store multiple cycle count wrong");

  property p_swp_cycles;
    @(posedge clk_sys) disable iff (rst)
    instrDone && ins_q.isSwap |-> cycCnt_q == `SWP_CYCLES;
  endproperty
  a_swp_cycles: assert property (p_swp_cycles)
    else $error("exchange cycle count wrong");
endmodule

// ===== test/mem_model.sv
// memory system and memory manager model on the far side of the sequencer
`timescale 1ns/10ps
module mem_model (
  // clock
  input wire logic clk_sys,
  // memory link
  input wire seq_pkg::memOut_t memOut,
  output seq_pkg::memIn_t memIn,
  // fault injection: bit 0 faults reads, bit 1 faults writes
  input wire logic [31:0] faultAddr,
  input wire logic [1:0] faultMode
);
  import seq_pkg::*;
  logic [31:0] mem [0:63];
  logic [31:0] lastQ = 32'h0;
  logic [31:0] word;
  logic hit;
  logic rdCyc;
  logic fault;
  assign word = mem[memOut.addr[7:2]];
  assign rdCyc = memOut.req && !memOut.we;
  assign hit = memOut.req && (memOut.addr[7:2] == faultAddr[7:2]);
  // any single word may fault, read or write side chosen by bench
  assign fault = hit && faultMode[memOut.we];
  // answer in the request cycle, never stalling a locked pair
  // idle bus shows inverted last word, not a stale copy
  assign memIn = {rdCyc ? word : ~lastQ, fault};
  always @(posedge clk_sys)
  begin
    if (rdCyc)
      lastQ <= word;
    // faulted writes are dropped
    if (memOut.req && memOut.we && !memIn.fault)
    begin
      if (memOut.byteXfer)
        mem[memOut.addr[7:2]][8*memOut.addr[1:0] +: 8] <= memOut.wdata[7:0];
      else
        mem[memOut.addr[7:2]] <= memOut.wdata;
    end
  end
endmodule

// ===== test/tb.sv
// self-checking bench for the block transfer and exchange sequencer
`timescale 1ns/10ps
`include "seq_consts.svh"
`define CHK(n,e,g) begin cmp_count++; if ((g) !== (e)) begin \
  $display("[FAIL] %s exp %h got %h", n, e, g); fail_count++; end end
module tb;
  import seq_pkg::*;
  logic clk_sys = 1'b0;
  logic rst, cyc, stb, we, ack_o, busy, irqInhibit, dataFaultTrap;
  logic instrDone, tr;
  logic [7:0] adr;
  logic [31:0] dat, dat_o, fAddr, v;
  logic [3:0] sel;
  logic [1:0] fMode;
  memOut_t memOut;
  memIn_t memIn;
  int fail_count = 0;
  int cmp_count = 0;
  int tc = 0;
  int bc, lc, ic, nc, j, k, s;
  always #20 clk_sys = ~clk_sys;
  block_transfer_swap_sequencer #(.LIST_W(16)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .dat_i(dat), .sel_i(sel), .ack_o(ack_o), .dat_o(dat_o),
    .memOut(memOut), .memIn(memIn), .busy(busy),
    .irqInhibit(irqInhibit), .dataFaultTrap(dataFaultTrap),
    .instrDone(instrDone));
  mem_model i_mem (.clk_sys(clk_sys), .memOut(memOut), .memIn(memIn),
    .faultAddr(fAddr), .faultMode(fMode));
  // busy, lock, inhibit and N cycle counts, trap seen
  always @(posedge clk_sys)
  begin
    if (busy === 1'b1)
      bc <= bc + 1;
    if (memOut.lock === 1'b1)
      lc <= lc + 1;
    if (irqInhibit === 1'b1)
      ic <= ic + 1;
    if (busy === 1'b1 && memOut.cyc === CYC_N)
      nc <= nc + 1;
    if (dataFaultTrap === 1'b1)
      tr <= 1'b1;
  end
  always @(posedge clk_sys)
  begin
    tc <= tc + 1;
    if (tc == 20000)
    begin
      fail_count++;
      conclude();
    end
  end
  task conclude;
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    @(posedge clk_sys);
    while (ack_o !== 1'b1)
      @(posedge clk_sys);
    v = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task setr(input logic [3:0] r, input logic [31:0] d);
    wb(1'b1, `OFS_REGS + {r, 2'h0}, d);
  endtask
  task chkr(input logic [3:0] r, input logic [31:0] e);
    wb(1'b0, `OFS_REGS + {r, 2'h0}, 32'h0);
    `CHK("reg", e, v)
  endtask
  // start one instruction, check its length and trap
  task run(input logic [31:0] ins, input int n, input logic t);
    bc = 0;
    lc = 0;
    ic = 0;
    nc = 0;
    tr = 1'b0;
    wb(1'b1, `OFS_INSTR, ins);
    j = 0;
    while (instrDone !== 1'b1 && j < 64)
    begin
      @(posedge clk_sys);
      j++;
    end
    @(posedge clk_sys);
    `CHK("cycles", n, bc)
    `CHK("trap", t, tr)
  endtask
  // m is pre, up, user-bank, write-back, load
  function automatic logic [31:0] blk(input logic [4:0] m,
    input logic [3:0] b, input logic [15:0] l);
    return {7'h04, m, b, l};
  endfunction
  function automatic logic [31:0] xchg(input logic by, input logic [3:0] b,
    input logic [3:0] d, input logic [3:0] sr);
    return {8'h01, 1'b0, by, 2'h0, b, d, 4'h0, 4'h9, sr};
  endfunction
  initial
  begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
    sel = 4'h0;
    fAddr = 32'h0;
    fMode = 2'h0;
    for (k = 0; k < 64; k++)
      i_mem.mem[k] = 32'ha000_0000 + k;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    wb(1'b0, `OFS_STATUS, 32'h0);
    `CHK("status", 32'h0, v)
    wb(1'b0, `OFS_CUR_SW, 32'h0);
    `CHK("cur_sw", `SW_RESET, v)
    // store, base first then base second
    setr(0, 32'h20);
    setr(1, 32'h111);
    setr(2, 32'h222);
    run(blk(5'h0a, 4'h0, 16'h0007), 4, 1'b0);
    `CHK("ncyc", 2, nc)
    `CHK("mem", 32'h20, i_mem.mem[8])
    `CHK("mem", 32'h222, i_mem.mem[10])
    chkr(0, 32'h2c);
    setr(1, 32'h40);
    run(blk(5'h0a, 4'h1, 16'h0007), 4, 1'b0);
    `CHK("mem", 32'h4c, i_mem.mem[17])
    // four addressing modes of load with write-back
    for (s = 0; s < 4; s++)
    begin
      setr(3, 32'h90);
      run(blk({s[1], s[0], 3'h3}, 4'h3, 16'h0006), 4, 1'b0);
      `CHK("ncyc", 1, nc)
      k = s[0] ? (s[1] ? 37 : 36) : (s[1] ? 34 : 35);
      chkr(1, 32'ha000_0000 + k);
      chkr(2, 32'ha000_0001 + k);
      chkr(3, s[0] ? 32'h98 : 32'h88);
    end
    setr(1, 32'h90);
    run(blk(5'h0b, 4'h1, 16'h0006), 4, 1'b0);
    chkr(1, 32'ha000_0024);
    // load faulting on third word, base and pc in list
    setr(1, 32'h90);
    setr(2, 32'h5);
    setr(15, 32'h7);
    fAddr <= 32'h98;
    fMode <= 2'h1;
    run(blk(5'h0b, 4'h1, 16'h8007), 6, 1'b1);
    chkr(0, 32'ha000_0024);
    chkr(1, 32'ha0);
    chkr(2, 32'h5);
    chkr(15, 32'h7);
    wb(1'b0, `OFS_STATUS, 32'h0);
    `CHK("fault", 1'b1, v[`STAT_FAULT])
    // store faulting on second word
    fAddr <= 32'h24;
    fMode <= 2'h2;
    setr(1, 32'h20);
    run(blk(5'h0a, 4'h1, 16'h000c), 3, 1'b1);
    chkr(1, 32'h28);
    `CHK("mem", 32'h111, i_mem.mem[9])
    fMode <= 2'h0;
    // pc load with user-bank bit restores status word
    wb(1'b1, `OFS_SAVED_SW, 32'h10);
    setr(3, 32'h90);
    run(blk(5'h0d, 4'h3, 16'h8000), 5, 1'b0);
    `CHK("ncyc", 2, nc)
    wb(1'b0, `OFS_CUR_SW, 32'h0);
    `CHK("cur_sw", 32'h10, v)
    chkr(15, 32'ha000_0024);
    wb(1'b1, `OFS_CUR_SW, `SW_RESET);
    // user bank store with pc, user bank load without pc
    wb(1'b1, `OFS_USER, 32'hbeef);
    setr(8, 32'h1234);
    setr(3, 32'h20);
    run(blk(5'h0c, 4'h3, 16'h8100), 3, 1'b0);
    `CHK("mem", 32'hbeef, i_mem.mem[8])
    setr(3, 32'h90);
    // user bank load of r8; visible r8 keeps its value, user copy read back
    run(blk(5'h0d, 4'h3, 16'h0100), 3, 1'b0);
    chkr(8, 32'h1234);
    wb(1'b0, `OFS_USER, 32'h0);
    `CHK("user", 32'ha000_0024, v)
    // word exchange
    i_mem.mem[12] = 32'h1122_3344;
    setr(4, 32'h30);
    setr(5, 32'hcafe_0001);
    run(xchg(1'b0, 4'h4, 4'h6, 4'h5), 4, 1'b0);
    `CHK("ncyc", 2, nc)
    `CHK("lock", 2, lc)
    `CHK("inhibit", 3, ic)
    chkr(6, 32'h1122_3344);
    `CHK("mem", 32'hcafe_0001, i_mem.mem[12])
    // byte exchange, source same as destination
    setr(4, 32'h32);
    setr(5, 32'h77);
    run(xchg(1'b1, 4'h4, 4'h5, 4'h5), 4, 1'b0);
    chkr(5, 32'hfe);
    `CHK("mem", 32'hca77_0001, i_mem.mem[12])
    // exchange fault on read, write and both
    fAddr <= 32'h30;
    for (s = 1; s < 4; s++)
    begin
      fMode <= s[1:0];
      run(xchg(1'b0, 4'h4, 4'h6, 4'h5), 4, 1'b1);
    end
    fMode <= 2'h0;
    conclude();
  end
endmodule
